// ### rtl/mcsr_map.svh
// Register offsets, reset values and timing counts for the monitor bank
`ifndef MCSR_MAP_SVH
`define MCSR_MAP_SVH
`define MCSR_IDX_EXT1     8'h76
`define MCSR_IDX_EXT2     8'h77
`define MCSR_IDX_CFG3     8'h78
`define MCSR_IDX_OTSTAT   8'h79
`define MCSR_IDX_OTLIM    8'h7A
`define MCSR_IDX_PULSES   8'h7B
`define MCSR_IDX_CFG4     8'h7D
`define MCSR_IDX_CTRL     8'h80
`define MCSR_RST_CFG3     8'h00
`define MCSR_RST_OTLIM    8'h00
`define MCSR_RST_PULSES   8'h55
`define MCSR_RST_CFG4     8'h00
`define MCSR_CFG4_WMASK   8'h0F
`define MCSR_B_ALERT      0
`define MCSR_B_OTEN       1
`define MCSR_B_FULL_SPEED_ON_OVERTEMP      2
`define MCSR_B_FAST       3
`define MCSR_B_DC0        4
`define MCSR_B_AL25       0
`define MCSR_B_SHARED_FIVE_VOLT_PIN_AS_OVERTEMP       1
`define MCSR_B_TWO_WIRE_FAN_THRESHOLD       2
`define MCSR_B_F4MASK     5
`define MCSR_STEP_US      22760
`define MCSR_CLK_MHZ      125
`define MCSR_STEP_CYC     (`MCSR_STEP_US * `MCSR_CLK_MHZ)
`define MCSR_SLOW_MS      1000
`define MCSR_FAST_MS      250
`endif

// ### rtl/mcsr_ot_if.sv
// Overtemperature timer link between bank and timer
`default_nettype none
interface mcsr_ot_if;
    logic       active;
    logic       clr;
    logic [7:0] status;
    logic       over;
    modport bank  (output active, output clr, input status, input over);
    modport timer (input active, input clr, output status, output over);
endinterface
`default_nettype wire

// ### rtl/mcsr_ot_timer.sv
// Overtemperature duration timer with saturating count
`include "mcsr_map.svh"
`default_nettype none
module mcsr_ot_timer
    import mcsr_pkg::*;
#(
    parameter int STEP_CYC = `MCSR_STEP_CYC
)(
    input  wire logic  sys_clk,
    input  wire logic  arst_n,
    input  wire logic [7:0] limit,
    mcsr_ot_if.timer   ot
);
    logic [31:0] pre_r;
    logic [7:0]  cnt_r;
    logic        seen_r;
    mcsr_tmr_t   st_r;
    wire         tick = ot.active && (pre_r == 32'(STEP_CYC - 1));
    wire [7:0]   cnt_inc = (cnt_r == 8'hFF) ? cnt_r : cnt_r + 8'h01;
    // Bits 7:1 stay hidden until two steps have passed
    wire         shown = (cnt_r >= 8'h02);
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
            pre_r <= 32'h0;
        else if (!ot.active || tick)
            pre_r <= 32'h0;
        else
            pre_r <= pre_r + 32'h1;
    end
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            cnt_r <= 8'h00;
            st_r  <= MCSR_IDLE;
        end
        else
        begin
            case (st_r)
                MCSR_IDLE: if (ot.active) st_r <= MCSR_RUN;
                MCSR_RUN:  if (cnt_r == 8'hFF) st_r <= MCSR_SAT;
                MCSR_SAT:  if (ot.clr) st_r <= MCSR_IDLE;
                default:   st_r <= MCSR_IDLE;
            endcase
            if (tick)
                cnt_r <= cnt_inc;
            else if (ot.clr)
                cnt_r <= 8'h00;
        end
    end
    // Set wins over the read clear
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
            seen_r <= 1'b0;
        else if (ot.active)
            seen_r <= 1'b1;
        else if (ot.clr)
            seen_r <= 1'b0;
    end
    assign ot.status = shown ? {cnt_r[7:1], 1'b1} : {7'h00, seen_r};
    assign ot.over = (limit == 8'h00) ? ot.active : (cnt_r > limit);
    a_seen_sets: assert property (@(posedge sys_clk) disable iff (!arst_n)
        ot.active |=> seen_r) else $error("seen flag not set");
    a_low_hidden: assert property (@(posedge sys_clk) disable iff (!arst_n)
        (cnt_r < 8'h02) |-> (ot.status[7:1] == 7'h00))
        else $error("upper bits shown early");
    a_count_sat: assert property (@(posedge sys_clk) disable iff (!arst_n)
        (cnt_r == 8'hFF && !ot.clr) |=> (cnt_r == 8'hFF))
        else $error("count wrapped");
    c_saturate: cover property (@(posedge sys_clk) disable iff (!arst_n)
        st_r == MCSR_SAT);
endmodule // mcsr_ot_timer
`default_nettype wire

// ### rtl/mcsr_pkg.sv
// Types shared by the monitor bank modules
`default_nettype none
package mcsr_pkg;
    typedef enum logic [2:0] {
        MCSR_IDLE = 3'b001,
        MCSR_RUN  = 3'b010,
        MCSR_SAT  = 3'b100
    } mcsr_tmr_t;
    typedef logic [7:0] mcsr_byte_t;
endpackage
`default_nettype wire

// ### rtl/mcsr_regs.sv
// APB register bank: low reading bits, pin config, overtemp timer, pulses
`include "mcsr_map.svh"
`default_nettype none
// Summary of operation
// - Register 0x76 returns low bits of 2.5V, core, main, 5V readings.
// - Register 0x77 returns low bits of 12V, remote1, local, remote2.
// - Reading a low-bit register freezes it and its upper bytes.
// - Alert-select bit turns shared fan-drive pin into alert output.
// - Monitor enable activates overtemp input on the selected pin.
// - Full-speed bit drives all fans at 100% during overtemp.
// - Fast bit measures every tachometer each 250 ms, else each second.
// - Per-fan continuous bits make that channel measure continuously.
// - Status bit 0 sets on overtemp assertion; read clears it.
// - Bits 7:1 read zero until 45.52 ms, then 22.76 ms count.
// - Duration over programmed limit sets interrupt status bit 5.
// - Limit zero raises the interrupt at once on assertion.
// - Two-bit pulse fields per fan, 00..11 mean 1..4, reset 0x55.
// - Config4 bit 0 makes shared 2.5V pin alert output.
// - Config4 bit 1 makes shared 5V pin the overtemp input.
// - Config4 bits 3:2 select two-wire fan detection threshold.
// - Lock bit makes config3 and config4 read-only.
// - Mask bit 5 of mask register 2 gates timer alert while the fan4 pin is the overtemp source.
module mcsr_regs
    import mcsr_pkg::*;
#(
    parameter int NFAN     = 4,
    parameter int STEP_CYC = `MCSR_STEP_CYC,
    parameter int SLOW_CYC = `MCSR_SLOW_MS * `MCSR_CLK_MHZ * 1000,
    parameter int FAST_CYC = `MCSR_FAST_MS * `MCSR_CLK_MHZ * 1000
)(
    input  wire logic        sys_clk,
    input  wire logic        arst_n,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic [9:0]  rd_low_supply,
    input  wire logic [9:0]  rd_cpu_core_supply,
    input  wire logic [9:0]  rd_main_supply,
    input  wire logic [9:0]  rd_five_volt,
    input  wire logic [9:0]  rd_twelve_volt,
    input  wire logic [9:0]  rd_remote1_temp,
    input  wire logic [9:0]  rd_local_temp,
    input  wire logic [9:0]  rd_remote2_temp,
    input  wire logic        rd_update,
    input  wire logic        config_lock,
    input  wire logic        fan4_or_timer_status_mask,
    input  wire logic        alert_request,
    input  wire logic        pin_fan4_overtemp,
    input  wire logic        pin_five_volt,
    output logic      [63:0] upper_bytes,
    output logic             fan_drive_pin_as_alert,
    output logic             alert_out,
    output logic             alert_oe,
    output logic             shared_low_supply_pin_as_alert,
    output logic             shared_five_volt_pin_as_overtemp,
    output logic      [1:0]  two_wire_fan_threshold,
    output logic             fans_full_speed,
    output logic      [NFAN-1:0] measure_go,
    output logic      [8:0]  fan_pulse_target,
    output logic             fan4_or_timer_status
);
    logic [7:0]  cfg3_r, lim_r, pul_r, cfg4_r, ext1_r, ext2_r;
    logic [63:0] hi_r;
    logic        frz1_r, frz2_r;
    logic [2:0]  p5_r, p4_r;
    logic        int_r;
    mcsr_ot_if   ot ();

    // Sampled pins: accept a change once the last two stages agree
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            p5_r <= 3'b000;
            p4_r <= 3'b000;
        end
        else
        begin
            p5_r <= {p5_r[1:0], pin_five_volt};
            p4_r <= {p4_r[1:0], pin_fan4_overtemp};
        end
    end
    logic ot5_r, ot4_r;
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            ot5_r <= 1'b0;
            ot4_r <= 1'b0;
        end
        else
        begin
            if (p5_r[2] == p5_r[1]) ot5_r <= p5_r[2];
            if (p4_r[2] == p4_r[1]) ot4_r <= p4_r[2];
        end
    end

    wire [7:0] idx = paddr[9:2];
    wire       acc = psel && penable;
    wire       wr  = acc && pwrite;
    wire       rd  = acc && !pwrite;
    wire       hit_ext1 = (idx == `MCSR_IDX_EXT1);
    wire       hit_ext2 = (idx == `MCSR_IDX_EXT2);
    wire       hit_cfg3 = (idx == `MCSR_IDX_CFG3);
    wire       hit_stat = (idx == `MCSR_IDX_OTSTAT);
    wire       hit_lim  = (idx == `MCSR_IDX_OTLIM);
    wire       hit_pul  = (idx == `MCSR_IDX_PULSES);
    wire       hit_cfg4 = (idx == `MCSR_IDX_CFG4);
    wire       hit_ctrl = (idx == `MCSR_IDX_CTRL);
    wire       mapped = hit_ext1 | hit_ext2 | hit_cfg3 | hit_stat |
                        hit_lim | hit_pul | hit_cfg4 | hit_ctrl;
    wire       bad = (paddr[11:10] != 2'b00) || (paddr[1:0] != 2'b00)
                     || !mapped;
    // Upper-byte read offsets live in the control window at 0x81..0x88
    wire       hit_hi = (idx >= 8'h81) && (idx <= 8'h88);
    wire [2:0] hi_sel = 3'(idx - 8'h81);
    wire       wr_cfg3 = wr && hit_cfg3 && !config_lock;
    wire       wr_cfg4 = wr && hit_cfg4 && !config_lock;

    // Registers software writes
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            cfg3_r <= `MCSR_RST_CFG3;
            lim_r  <= `MCSR_RST_OTLIM;
            pul_r  <= `MCSR_RST_PULSES;
            cfg4_r <= `MCSR_RST_CFG4;
        end
        else
        begin
            if (wr_cfg3) cfg3_r <= pwdata[7:0];
            if (wr && hit_lim) lim_r <= pwdata[7:0];
            if (wr && hit_pul) pul_r <= pwdata[7:0];
            if (wr_cfg4) cfg4_r <= pwdata[7:0] & `MCSR_CFG4_WMASK;
        end
    end

    // Freeze: low-bit read latches, upper-byte read releases
    wire rd_ext1 = rd && hit_ext1 && !bad;
    wire rd_ext2 = rd && hit_ext2 && !bad;
    wire rd_hi   = rd && hit_hi;
    wire rel1 = rd_hi && (hi_sel < 3'd4);
    wire rel2 = rd_hi && (hi_sel >= 3'd4);
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            frz1_r <= 1'b0;
            frz2_r <= 1'b0;
        end
        else
        begin
            frz1_r <= rd_ext1 | (frz1_r & !rel1);
            frz2_r <= rd_ext2 | (frz2_r & !rel2);
        end
    end
    wire [79:0] rd_all = {rd_remote2_temp, rd_local_temp, rd_remote1_temp,
                          rd_twelve_volt, rd_five_volt, rd_main_supply,
                          rd_cpu_core_supply, rd_low_supply};
    logic [7:0] lo_nxt [8];
    for (genvar g = 0; g < 8; g++)
    begin : g_rd
        wire frz = (g < 4) ? frz1_r : frz2_r;
        always_ff @(posedge sys_clk or negedge arst_n)
        begin
            if (!arst_n)
                hi_r[g*8 +: 8] <= 8'h00;
            else if (rd_update && !frz)
                hi_r[g*8 +: 8] <= rd_all[g*10+2 +: 8];
        end
        assign lo_nxt[g] = {6'h00, rd_all[g*10 +: 2]};
    end
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            ext1_r <= 8'h00;
            ext2_r <= 8'h00;
        end
        else if (rd_update)
        begin
            if (!frz1_r)
                ext1_r <= {lo_nxt[3][1:0], lo_nxt[2][1:0],
                           lo_nxt[1][1:0], lo_nxt[0][1:0]};
            if (!frz2_r)
                ext2_r <= {lo_nxt[7][1:0], lo_nxt[6][1:0],
                           lo_nxt[5][1:0], lo_nxt[4][1:0]};
        end
    end

    // Overtemp source selection
    wire ot_pin = cfg4_r[`MCSR_B_SHARED_FIVE_VOLT_PIN_AS_OVERTEMP] ? ot5_r : ot4_r;
    assign ot.active = cfg3_r[`MCSR_B_OTEN] && ot_pin;
    assign ot.clr = rd && hit_stat && !bad;
    mcsr_ot_timer #(.STEP_CYC(STEP_CYC)) u_timer (
        .sys_clk (sys_clk),
        .arst_n  (arst_n),
        .limit   (lim_r),
        .ot      (ot.timer)
    );
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
            int_r <= 1'b0;
        else if (ot.over)
            int_r <= 1'b1;
        else if (wr && hit_ctrl && pwdata[`MCSR_B_F4MASK])
            int_r <= 1'b0;
    end
    assign fan4_or_timer_status = int_r;

    mcsr_tach_sched #(
        .NFAN     (NFAN),
        .SLOW_CYC (SLOW_CYC),
        .FAST_CYC (FAST_CYC)
    ) u_tach (
        .sys_clk    (sys_clk),
        .arst_n     (arst_n),
        .fast       (cfg3_r[`MCSR_B_FAST]),
        .cont       (cfg3_r[`MCSR_B_DC0 +: NFAN]),
        .measure_go (measure_go)
    );

    // Pulse targets: encoded value plus one per fan
    for (genvar f = 0; f < 3; f++)
    begin : g_pul
        assign fan_pulse_target[f*3 +: 3] = {1'b0, pul_r[f*2 +: 2]} + 3'd1;
    end
    wire [2:0] p4_tgt = {1'b0, pul_r[7:6]} + 3'd1;
    wire       timer_alert = int_r && !(!cfg4_r[`MCSR_B_SHARED_FIVE_VOLT_PIN_AS_OVERTEMP] &&
                             fan4_or_timer_status_mask);
    assign fans_full_speed = cfg3_r[`MCSR_B_FULL_SPEED_ON_OVERTEMP] && ot.active;
    assign fan_drive_pin_as_alert = cfg3_r[`MCSR_B_ALERT];
    assign shared_low_supply_pin_as_alert = cfg4_r[`MCSR_B_AL25];
    assign shared_five_volt_pin_as_overtemp = cfg4_r[`MCSR_B_SHARED_FIVE_VOLT_PIN_AS_OVERTEMP];
    assign two_wire_fan_threshold = cfg4_r[`MCSR_B_TWO_WIRE_FAN_THRESHOLD +: 2];
    // Alert is open drain: pull low while asserted on either shared pin
    assign alert_oe = (cfg3_r[`MCSR_B_ALERT] | cfg4_r[`MCSR_B_AL25]) &&
                      (alert_request | timer_alert);
    assign alert_out = 1'b0;
    assign upper_bytes = hi_r;

    // Read mux
    logic [7:0] rmux;
    assign rmux = hit_ext1 ? ext1_r :
                  hit_ext2 ? ext2_r :
                  hit_cfg3 ? cfg3_r :
                  hit_stat ? ot.status :
                  hit_lim  ? lim_r :
                  hit_pul  ? pul_r :
                  hit_cfg4 ? cfg4_r :
                  hit_ctrl ? {5'h00, p4_tgt} :
                  8'h00;
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
            prdata <= 32'h0;
        else if (psel && !penable && !pwrite)
            prdata <= hit_hi ? {24'h0, hi_r[hi_sel*8 +: 8]} : {24'h0, rmux};
    end
    assign pready  = 1'b1;
    assign pslverr = acc && bad && !hit_hi;

    a_lock_cfg3: assert property (@(posedge sys_clk) disable iff (!arst_n)
        (config_lock && wr && hit_cfg3) |=> $stable(cfg3_r))
        else $error("locked config3 written");
    a_cfg4_upper: assert property (@(posedge sys_clk) disable iff (!arst_n)
        cfg4_r[7:4] == 4'h0) else $error("config4 upper bits set");
    a_full_speed_on_overtemp_ties: assert property (@(posedge sys_clk) disable iff (!arst_n)
        (cfg3_r[2] && cfg3_r[1] && ot_pin) |-> fans_full_speed)
        else $error("full speed missing");
    a_freeze_hold: assert property (@(posedge sys_clk) disable iff (!arst_n)
        (frz1_r && !rel1) |=> $stable(ext1_r))
        else $error("frozen register changed");
    a_lim_zero: assert property (@(posedge sys_clk) disable iff (!arst_n)
        (lim_r == 8'h00 && ot.active) |=> int_r)
        else $error("zero limit no interrupt");
    c_freeze: cover property (@(posedge sys_clk) disable iff (!arst_n)
        rd_ext1 ##[1:20] rel1);
    c_full_speed_on_overtemp: cover property (@(posedge sys_clk) disable iff (!arst_n)
        fans_full_speed);
    c_lock: cover property (@(posedge sys_clk) disable iff (!arst_n)
        config_lock && wr && hit_cfg4);
endmodule // mcsr_regs
`default_nettype wire

// ### rtl/mcsr_tach_sched.sv
// Tachometer measurement scheduler per fan channel
`include "mcsr_map.svh"
`default_nettype none
module mcsr_tach_sched #(
    parameter int NFAN   = 4,
    parameter int SLOW_CYC = `MCSR_SLOW_MS * `MCSR_CLK_MHZ * 1000,
    parameter int FAST_CYC = `MCSR_FAST_MS * `MCSR_CLK_MHZ * 1000
)(
    input  wire logic            sys_clk,
    input  wire logic            arst_n,
    input  wire logic            fast,
    input  wire logic [NFAN-1:0] cont,
    output logic      [NFAN-1:0] measure_go
);
    logic [31:0] per_r;
    wire  [31:0] lim = fast ? 32'(FAST_CYC - 1) : 32'(SLOW_CYC - 1);
    wire         due = (per_r >= lim);
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
            per_r <= 32'h0;
        else if (due)
            per_r <= 32'h0;
        else
            per_r <= per_r + 32'h1;
    end
    for (genvar i = 0; i < NFAN; i++)
    begin : g_fan
        assign measure_go[i] = cont[i] | due;
    end
    a_period_fast: assert property (@(posedge sys_clk) disable iff (!arst_n)
        (fast && per_r > 32'(FAST_CYC - 1)) |=> (per_r == 32'h0))
        else $error("fast period overrun");
    a_cont_go: assert property (@(posedge sys_clk) disable iff (!arst_n)
        cont[0] |-> measure_go[0]) else $error("continuous not honoured");
endmodule // mcsr_tach_sched
`default_nettype wire

// ### sim/mcsr_front_model.sv
// Partner model of the converter front end that feeds ten-bit readings
`default_nettype none
module mcsr_front_model (
    input  wire logic            sys_clk,
    input  wire logic            arst_n,
    input  wire logic            go,
    input  wire logic [7:0]      seed,
    output logic      [7:0][9:0] rd_all,
    output logic                 rd_update
);
    timeunit 1ns;
    timeprecision 100ps;
    // Values and strobe land together, so the bank sees fresh data
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            rd_all    <= '0;
            rd_update <= 1'b0;
        end
        else
        begin
            rd_update <= go;
            for (int g = 0; g < 8; g++)
            begin
                if (go)
                    rd_all[g] <= {seed + 8'(g), 2'(g) ^ seed[1:0]};
            end
        end
    end
endmodule // mcsr_front_model
`default_nettype wire

// ### sim/monitor_config_status_regs_tb_top.sv
// Self-checking bench for the monitor register bank
`default_nettype none
module monitor_config_status_regs_tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int STEP = 20;
    logic sys_clk = 1'b0;
    logic arst_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0;
    logic [31:0] prdata;
    logic pready, pslverr, rd_update, go = 1'b0;
    logic [7:0] seed = '0;
    logic [7:0][9:0] rd_all;
    logic config_lock = 1'b0;
    logic fan4_or_timer_status_mask = 1'b0;
    logic alert_request = 1'b0;
    logic pin_fan4_overtemp = 1'b0;
    logic pin_five_volt = 1'b0;
    logic [63:0] upper_bytes;
    logic fan_drive_pin_as_alert, alert_out, alert_oe, fans_full_speed;
    logic shared_low_supply_pin_as_alert, shared_five_volt_pin_as_overtemp;
    logic [1:0] two_wire_fan_threshold;
    logic [3:0] measure_go;
    logic [8:0] fan_pulse_target;
    logic fan4_or_timer_status;
    int n_mismatch = 0;
    int n_tests = 0;

    always #4 sys_clk = ~sys_clk;

    mcsr_front_model u_front (.sys_clk, .arst_n, .go, .seed, .rd_all,
        .rd_update);

    // Short counts keep the overtemp and tach runs brief
    mcsr_regs #(.NFAN(4), .STEP_CYC(STEP), .SLOW_CYC(40), .FAST_CYC(10))
    u_dut (.sys_clk, .arst_n, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .rd_low_supply(rd_all[0]),
        .rd_cpu_core_supply(rd_all[1]), .rd_main_supply(rd_all[2]),
        .rd_five_volt(rd_all[3]), .rd_twelve_volt(rd_all[4]),
        .rd_remote1_temp(rd_all[5]), .rd_local_temp(rd_all[6]),
        .rd_remote2_temp(rd_all[7]), .rd_update, .config_lock,
        .fan4_or_timer_status_mask, .alert_request, .pin_fan4_overtemp,
        .pin_five_volt, .upper_bytes, .fan_drive_pin_as_alert, .alert_out,
        .alert_oe, .shared_low_supply_pin_as_alert,
        .shared_five_volt_pin_as_overtemp, .two_wire_fan_threshold,
        .fans_full_speed, .measure_go, .fan_pulse_target,
        .fan4_or_timer_status);

    task automatic finish_test();
        $display("tests %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask

    task automatic apb(input logic wr, input logic [7:0] idx,
        input logic [7:0] d, output logic [31:0] rd, output logic err);
        int k;
        @(posedge sys_clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= {2'b00, idx, 2'b00};
        pwdata <= {24'h0, d};
        @(posedge sys_clk);
        penable <= 1'b1;
        k = 0;
        do
        begin
            @(posedge sys_clk);
            k++;
        end
        while (pready !== 1'b1 && k < 50);
        if (k >= 50)
        begin
            n_mismatch++;
            finish_test();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        #1;
    endtask

    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, idx, d, r, e);
    endtask

    task automatic rc(input logic [7:0] idx, input logic [7:0] exp);
        logic [31:0] r;
        logic e;
        apb(1'b0, idx, 8'h00, r, e);
        chk(r, {24'h0, exp});
    endtask

    task automatic load(input logic [7:0] s);
        @(posedge sys_clk);
        seed <= s;
        go <= 1'b1;
        @(posedge sys_clk);
        go <= 1'b0;
        cyc(3);
    endtask

    function automatic logic [7:0] lows(input logic [7:0] s);
        for (int g = 0; g < 4; g++)
            lows[2*g +: 2] = 2'(g) ^ s[1:0];
    endfunction

    function automatic logic [63:0] ups(input logic [7:0] s);
        for (int g = 0; g < 8; g++)
            ups[8*g +: 8] = s + 8'(g);
    endfunction

    // Holds the selected overtemp pin for n cycles, then lets it settle
    task automatic ot_pulse(input logic five, input int n);
        @(posedge sys_clk);
        if (five)
            pin_five_volt <= 1'b1;
        else
            pin_fan4_overtemp <= 1'b1;
        cyc(n);
        pin_five_volt <= 1'b0;
        pin_fan4_overtemp <= 1'b0;
        cyc(6);
    endtask

    initial
    begin
        logic [31:0] d;
        logic e;
        int c;
        logic [3:0] m;
        repeat (16) @(posedge sys_clk);
        arst_n <= 1'b1;
        rc(8'h78, 8'h00);
        rc(8'h7A, 8'h00);
        rc(8'h7B, 8'h55);
        rc(8'h7D, 8'h00);
        rc(8'h79, 8'h00);
        wr(8'h78, 8'hF1);
        rc(8'h78, 8'hF1);
        chk(fan_drive_pin_as_alert, 1);
        alert_request <= 1'b1;
        cyc(2);
        chk(alert_oe, 1);
        alert_request <= 1'b0;
        for (int i = 0; i < 4; i++)
        begin
            wr(8'h78, 8'(8'h10 << i));
            // Period strobe never stands two cycles running
            m = measure_go;
            cyc(1);
            chk(m & measure_go, 4'h1 << i);
        end
        foreach (measure_go[i])
            wr(8'h78, 8'h00);
        wr(8'h7B, 8'h1B);
        chk(fan_pulse_target, {3'd2, 3'd3, 3'd4});
        rc(8'h80, 8'h01);
        wr(8'h7B, 8'hE4);
        chk(fan_pulse_target, {3'd3, 3'd2, 3'd1});
        rc(8'h80, 8'h04);
        wr(8'h7D, 8'hFF);
        rc(8'h7D, 8'h0F);
        chk(shared_low_supply_pin_as_alert, 1);
        chk(shared_five_volt_pin_as_overtemp, 1);
        for (int t = 0; t < 4; t++)
        begin
            wr(8'h7D, 8'(t << 2));
            chk(two_wire_fan_threshold, t);
        end
        chk(shared_low_supply_pin_as_alert, 0);
        config_lock <= 1'b1;
        wr(8'h78, 8'hFF);
        wr(8'h7D, 8'h03);
        rc(8'h78, 8'h00);
        rc(8'h7D, 8'h0C);
        config_lock <= 1'b0;
        apb(1'b0, 8'h7C, 8'h00, d, e);
        chk(e, 1);
        chk(d, 0);
        // Freeze: both groups read, then new data must not show through
        load(8'h40);
        wr(8'h76, 8'hFF);
        rc(8'h76, lows(8'h40));
        rc(8'h77, lows(8'h40));
        load(8'h93);
        chk(upper_bytes, ups(8'h40));
        rc(8'h76, lows(8'h40));
        rc(8'h81, 8'h40);
        rc(8'h85, 8'h44);
        load(8'h93);
        chk(upper_bytes, ups(8'h93));
        rc(8'h77, lows(8'h93));
        // Overtemp on the five volt pin, full speed requested
        wr(8'h7D, 8'h02);
        wr(8'h7A, 8'h05);
        wr(8'h78, 8'h04);
        ot_pulse(1'b1, 10);
        rc(8'h79, 8'h00);
        wr(8'h78, 8'h06);
        @(posedge sys_clk);
        pin_fan4_overtemp <= 1'b1;
        cyc(8);
        chk(fans_full_speed, 0);
        pin_fan4_overtemp <= 1'b0;
        pin_five_volt <= 1'b1;
        cyc(6);
        chk(fans_full_speed, 1);
        cyc(5 * STEP + 4);
        pin_five_volt <= 1'b0;
        cyc(6);
        chk(fans_full_speed, 0);
        rc(8'h79, 8'h05);
        rc(8'h79, 8'h00);
        ot_pulse(1'b1, 5);
        rc(8'h79, 8'h01);
        ot_pulse(1'b1, 270 * STEP);
        rc(8'h79, 8'hFF);
        rc(8'h79, 8'h00);
        // Limit of three steps: not over at two, over at four
        wr(8'h80, 8'h20);
        wr(8'h7A, 8'h03);
        ot_pulse(1'b1, 2 * STEP + 8);
        chk(fan4_or_timer_status, 0);
        // Clear the two-step count so the next run starts from zero
        rc(8'h79, 8'h03);
        ot_pulse(1'b1, 4 * STEP + 8);
        chk(fan4_or_timer_status, 1);
        // Count still over the limit would set the flag again
        rc(8'h79, 8'h05);
        wr(8'h80, 8'h20);
        chk(fan4_or_timer_status, 0);
        // Fan4 pin as source, zero limit, alert gated by mask
        wr(8'h7D, 8'h00);
        wr(8'h7A, 8'h00);
        wr(8'h78, 8'h03);
        fan4_or_timer_status_mask <= 1'b1;
        ot_pulse(1'b1, 8);
        chk(fan4_or_timer_status, 0);
        ot_pulse(1'b0, 8);
        chk(fan4_or_timer_status, 1);
        chk(alert_oe, 0);
        fan4_or_timer_status_mask <= 1'b0;
        cyc(2);
        chk(alert_oe, 1);
        wr(8'h80, 8'h20);
        // Tach schedule rate, fast then slow
        for (int f = 1; f >= 0; f--)
        begin
            wr(8'h78, f ? 8'h08 : 8'h00);
            c = 0;
            repeat (200)
            begin
                @(posedge sys_clk);
                c += int'(measure_go[0] === 1'b1);
            end
            chk(f ? (c >= 19 && c <= 21) : (c >= 4 && c <= 6), 1);
        end
        finish_test();
    end
endmodule // monitor_config_status_regs_tb_top
`default_nettype wire
